// ==== src/ds3tx_map.svh ====
`ifndef DS3TX_MAP_SVH
`define DS3TX_MAP_SVH
// Register indices; byte address is four times the index
`define DS3TX_IDX_MASK_MID 8'h1a
`define DS3TX_IDX_MASK_LOW 8'h1b
`define DS3TX_IDX_CTRL 8'h1c
`define DS3TX_IDX_CODE 8'h1d
`define DS3TX_IDX_IRQ_STS 8'h20
`define DS3TX_IDX_IRQ_MSK 8'h21
// Control register fields
`define DS3TX_CTRL_IRQ_EN 4
`define DS3TX_CTRL_FLAG 3
`define DS3TX_CTRL_SEND_EN 2
`define DS3TX_CTRL_TRIG 1
`define DS3TX_CTRL_BUSY 0
// Code register field
`define DS3TX_CODE_LSB 1
`define DS3TX_CODE_MSB 6
// Reset values
`define DS3TX_RST_MASK 8'h00
`define DS3TX_RST_CODE 6'h3f
// Frame and message shape
`define DS3TX_FBITS 28
`define DS3TX_FIDX_LAST 5'h1b
`define DS3TX_MSG_BITS 16
`define DS3TX_MSG_LAST 4'hf
`define DS3TX_MSG_REPEAT_LAST 4'h9
`endif

// ==== src/ds3tx_pkg.sv ====
package ds3tx_pkg;
  // Register selected by an APB address
  typedef enum logic [2:0] {SEL_NONE, SEL_MID, SEL_LOW, SEL_CTRL, SEL_CODE, SEL_STS, SEL_MSK}
    ds3tx_sel_t;
  typedef enum logic {SER_IDLE, SER_SEND} ds3tx_ser_st_t;
  typedef struct packed {
    logic [7:0] mask_mid;
    logic [7:0] mask_low;
    logic irq_en;
    logic flag;
    logic send_en;
    logic trig;
    logic [5:0] code;
    logic done_sts;
    logic done_msk;
    logic [31:0] rdata;
  } ds3tx_regs_t;
  typedef struct packed {
    ds3tx_ser_st_t st;
    logic [3:0] bitcnt;
    logic [3:0] repcnt;
    logic [15:0] shreg;
    logic bit_out;
    logic done;
  } ds3tx_ser_t;
  typedef struct packed {
    logic [4:0] idx;
    logic bit_out;
    logic valid_out;
  } ds3tx_fx_t;
endpackage

// ==== src/ds3tx_fbit_xor.sv ====
`include "ds3tx_map.svh"
module ds3tx_fbit_xor (
  input wire logic clk,
  input wire logic rst,
  input wire logic [27:0] pattern,
  input wire logic bit_in,
  input wire logic bit_valid,
  input wire logic fbit_slot,
  input wire logic mframe_start,
  output logic bit_out,
  output logic bit_valid_out
);
  ds3tx_pkg::ds3tx_fx_t s_ff, nxt_s;
  logic [4:0] cur_idx;

  // F-bit position within the M-frame, restarted by the frame marker
  always_comb
  begin
    nxt_s = s_ff;
    cur_idx = mframe_start ? 5'h00 : s_ff.idx;
    nxt_s.valid_out = bit_valid;
    if (bit_valid)
    begin
      nxt_s.bit_out = bit_in;
      if (fbit_slot)
      begin
        nxt_s.bit_out = bit_in ^ pattern[cur_idx];
        // Hold at the last index so a missing marker never reads past bit 27
        nxt_s.idx = (cur_idx == `DS3TX_FIDX_LAST) ? cur_idx : cur_idx + 5'h01;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign bit_out = s_ff.bit_out;
  assign bit_valid_out = s_ff.valid_out;

  a_fbit_first_idx: assert property (@(posedge clk) disable iff (rst)
    bit_valid && fbit_slot && mframe_start |=> bit_out == ($past(bit_in) ^ $past(pattern[0])))
    else $error("first F-bit not xored with pattern bit 0");
  a_fbit_pass_data: assert property (@(posedge clk) disable iff (rst)
    bit_valid && !fbit_slot |=> bit_out == $past(bit_in))
    else $error("payload bit altered");
endmodule // ds3tx_fbit_xor

// ==== src/ds3tx_feac_ser.sv ====
`include "ds3tx_map.svh"
module ds3tx_feac_ser (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [5:0] code,
  input wire logic slot,
  output logic busy,
  output logic msg_bit,
  output logic done
);
  ds3tx_pkg::ds3tx_ser_t s_ff, nxt_s;

  // Code word framed as 0, code LSB first, 0, eight ones; repeated per message
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    case (s_ff.st)
      ds3tx_pkg::SER_IDLE:
      begin
        nxt_s.bit_out = 1'b1;
        if (start)
        begin
          nxt_s.st = ds3tx_pkg::SER_SEND;
          nxt_s.shreg = {8'hff, 1'b0, code, 1'b0};
          nxt_s.bitcnt = 4'h0;
          nxt_s.repcnt = 4'h0;
        end
      end
      ds3tx_pkg::SER_SEND:
      begin
        if (slot)
        begin
          nxt_s.bit_out = s_ff.shreg[0];
          nxt_s.shreg = {s_ff.shreg[0], s_ff.shreg[15:1]};
          nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
          if (s_ff.bitcnt == `DS3TX_MSG_LAST)
          begin
            nxt_s.repcnt = s_ff.repcnt + 4'h1;
            if (s_ff.repcnt == `DS3TX_MSG_REPEAT_LAST)
            begin
              nxt_s.st = ds3tx_pkg::SER_IDLE;
              nxt_s.done = 1'b1;
            end
          end
        end
      end
      default: nxt_s.st = ds3tx_pkg::SER_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_ff <= '{st: ds3tx_pkg::SER_IDLE, bitcnt: 4'h0, repcnt: 4'h0, shreg: 16'h0000,
                bit_out: 1'b1, done: 1'b0};
    else
      s_ff <= nxt_s;
  end

  assign busy = (s_ff.st == ds3tx_pkg::SER_SEND);
  assign msg_bit = s_ff.bit_out;
  assign done = s_ff.done;

  a_ser_done_idle: assert property (@(posedge clk) disable iff (rst)
    done |-> !busy && $past(busy))
    else $error("done without end of sending");
endmodule // ds3tx_feac_ser

// ==== src/ds3tx_top.sv ====
`include "ds3tx_map.svh"
module ds3tx_top (
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Framer configuration, same clock
  input wire logic cbit_parity_mode,
  // Outbound bit stream
  input wire logic tx_bit_in,
  input wire logic tx_bit_valid,
  input wire logic tx_fbit_slot,
  input wire logic tx_mframe_start,
  output logic tx_bit_out,
  output logic tx_bit_valid_out,
  // Alarm message bit toward the C-bit slot
  input wire logic alarm_slot,
  output logic alarm_msg_bit,
  // Interrupt
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  ////////////////////////////////////////////////////////////////////////////

  // Shared by the read and write paths so both agree on the map
  function automatic ds3tx_pkg::ds3tx_sel_t reg_sel(input logic [7:0] addr);
    reg_sel = ds3tx_pkg::SEL_NONE;
    if (addr[1:0] == 2'b00)
    begin
      // Widened so the index meets the 8-bit map constants at equal width
      case ({2'b00, addr[7:2]})
        `DS3TX_IDX_MASK_MID: reg_sel = ds3tx_pkg::SEL_MID;
        `DS3TX_IDX_MASK_LOW: reg_sel = ds3tx_pkg::SEL_LOW;
        `DS3TX_IDX_CTRL: reg_sel = ds3tx_pkg::SEL_CTRL;
        `DS3TX_IDX_CODE: reg_sel = ds3tx_pkg::SEL_CODE;
        `DS3TX_IDX_IRQ_STS: reg_sel = ds3tx_pkg::SEL_STS;
        `DS3TX_IDX_IRQ_MSK: reg_sel = ds3tx_pkg::SEL_MSK;
        default: reg_sel = ds3tx_pkg::SEL_NONE;
      endcase
    end
  endfunction

  ds3tx_pkg::ds3tx_regs_t r_ff, nxt_r;
  ds3tx_pkg::ds3tx_sel_t sel;
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic rd_en;
  logic alarm_msg_sending;
  logic ser_done;
  logic start_req;
  logic done_req;
  logic [27:0] framing_bit_xor_pattern;
  logic [7:0] ctrl_view;
  logic [7:0] wbyte;

  assign sel = reg_sel(paddr);
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  // Zero wait states: read data is captured in the setup cycle
  assign pready = access_ph;
  assign pslverr = access_ph && (sel == ds3tx_pkg::SEL_NONE);
  assign wr_en = access_ph && pwrite && pstrb[0] && (sel != ds3tx_pkg::SEL_NONE);
  assign rd_en = access_ph && !pwrite;
  assign wbyte = pwdata[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Alarm message control
  ////////////////////////////////////////////////////////////////////////////

  // Start only on a fresh rising write of the trigger, enabled, idle, in C-bit mode
  assign start_req = wr_en && (sel == ds3tx_pkg::SEL_CTRL)
                     && wbyte[`DS3TX_CTRL_TRIG] && !r_ff.trig
                     && wbyte[`DS3TX_CTRL_SEND_EN]
                     && !alarm_msg_sending
                     && cbit_parity_mode;

  // Interrupt request at message end, blocked by the enable and outside C-bit mode
  assign done_req = ser_done && r_ff.irq_en && cbit_parity_mode;

  // Upper bits are constant zero, so writes there have no effect
  assign ctrl_view = {3'b000, r_ff.irq_en, r_ff.flag, r_ff.send_en, r_ff.trig,
                      alarm_msg_sending};

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  ////////////////////////////////////////////////////////////////////////////

  // Set always wins over the clear-on-read and the write-one-to-clear
  always_comb
  begin
    nxt_r = r_ff;
    if (setup_ph)
    begin
      nxt_r.rdata = 32'h00000000;
      case (sel)
        ds3tx_pkg::SEL_MID: nxt_r.rdata[7:0] = r_ff.mask_mid;
        ds3tx_pkg::SEL_LOW: nxt_r.rdata[7:0] = r_ff.mask_low;
        ds3tx_pkg::SEL_CTRL: nxt_r.rdata[7:0] = ctrl_view;
        ds3tx_pkg::SEL_CODE: nxt_r.rdata[7:0] = {1'b0, r_ff.code, 1'b0};
        ds3tx_pkg::SEL_STS: nxt_r.rdata[0] = r_ff.done_sts;
        ds3tx_pkg::SEL_MSK: nxt_r.rdata[0] = r_ff.done_msk;
        default: nxt_r.rdata = 32'h00000000;
      endcase
    end
    if (wr_en)
    begin
      case (sel)
        ds3tx_pkg::SEL_MID: nxt_r.mask_mid = wbyte;
        ds3tx_pkg::SEL_LOW: nxt_r.mask_low = wbyte;
        ds3tx_pkg::SEL_CTRL:
        begin
          nxt_r.irq_en = wbyte[`DS3TX_CTRL_IRQ_EN];
          nxt_r.send_en = wbyte[`DS3TX_CTRL_SEND_EN];
          nxt_r.trig = wbyte[`DS3TX_CTRL_TRIG];
        end
        ds3tx_pkg::SEL_CODE: nxt_r.code = wbyte[`DS3TX_CODE_MSB:`DS3TX_CODE_LSB];
        ds3tx_pkg::SEL_STS:
        begin
          if (wbyte[0])
            nxt_r.done_sts = 1'b0;
        end
        ds3tx_pkg::SEL_MSK: nxt_r.done_msk = wbyte[0];
        default: nxt_r.done_msk = r_ff.done_msk;
      endcase
    end
    // Reading the control register clears the flag
    if (rd_en && (sel == ds3tx_pkg::SEL_CTRL))
      nxt_r.flag = 1'b0;
    if (done_req)
    begin
      nxt_r.flag = 1'b1;
      nxt_r.done_sts = 1'b1;
    end
  end

  // Pattern and flags clear at reset; the code word comes up all ones
  always_ff @(posedge clk)
  begin
    if (rst)
      r_ff <= '{mask_mid: `DS3TX_RST_MASK, mask_low: `DS3TX_RST_MASK, irq_en: 1'b0,
                flag: 1'b0, send_en: 1'b0, trig: 1'b0, code: `DS3TX_RST_CODE,
                done_sts: 1'b0, done_msk: 1'b0, rdata: 32'h00000000};
    else
      r_ff <= nxt_r;
  end

  assign prdata = r_ff.rdata;
  // Level output, gated by the done enable and the mode as well as the mask
  assign irq = r_ff.done_sts && r_ff.done_msk && r_ff.irq_en && cbit_parity_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Datapath
  ////////////////////////////////////////////////////////////////////////////

  // The top pattern bits are not held here and stay zero
  assign framing_bit_xor_pattern = {12'h000, r_ff.mask_mid, r_ff.mask_low};

  ds3tx_fbit_xor ds3tx_fbit_xor_i (
    .clk(clk),
    .rst(rst),
    .pattern(framing_bit_xor_pattern),
    .bit_in(tx_bit_in),
    .bit_valid(tx_bit_valid),
    .fbit_slot(tx_fbit_slot),
    .mframe_start(tx_mframe_start),
    .bit_out(tx_bit_out),
    .bit_valid_out(tx_bit_valid_out)
  );

  ds3tx_feac_ser ds3tx_feac_ser_i (
    .clk(clk),
    .rst(rst),
    .start(start_req),
    .code(r_ff.code),
    .slot(alarm_slot),
    .busy(alarm_msg_sending),
    .msg_bit(alarm_msg_bit),
    .done(ser_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  ////////////////////////////////////////////////////////////////////////////

  a_fbit_invert: assert property (@(posedge clk) disable iff (rst)
    tx_bit_valid && tx_fbit_slot && tx_mframe_start && r_ff.mask_low[0]
    |=> tx_bit_out != $past(tx_bit_in))
    else $error("masked F-bit not inverted");
  a_start_busy: assert property (@(posedge clk) disable iff (rst)
    start_req |=> alarm_msg_sending)
    else $error("message did not start on trigger edge");
  a_no_start_dis: assert property (@(posedge clk) disable iff (rst)
    !alarm_msg_sending && !(wr_en && sel == ds3tx_pkg::SEL_CTRL && wbyte[2])
    |=> !alarm_msg_sending)
    else $error("message started while sender disabled");
  a_inert_mode: assert property (@(posedge clk) disable iff (rst)
    !cbit_parity_mode && !alarm_msg_sending |=> !alarm_msg_sending)
    else $error("alarm logic active outside C-bit mode");
  // The flag must not be set by a message end seen outside C-bit mode
  a_inert_flag: assert property (@(posedge clk) disable iff (rst)
    !cbit_parity_mode && !r_ff.flag |=> !r_ff.flag)
    else $error("flag set outside C-bit mode");
  a_flag_set: assert property (@(posedge clk) disable iff (rst)
    done_req |=> r_ff.flag && r_ff.done_sts)
    else $error("flag not set on message end");
  a_flag_rdclr: assert property (@(posedge clk) disable iff (rst)
    rd_en && sel == ds3tx_pkg::SEL_CTRL && !done_req |=> !r_ff.flag)
    else $error("flag not cleared by read");
  a_irq_gate: assert property (@(posedge clk) disable iff (rst)
    !r_ff.irq_en |-> !irq)
    else $error("interrupt not gated by enable");
  a_busy_read: assert property (@(posedge clk) disable iff (rst)
    setup_ph && sel == ds3tx_pkg::SEL_CTRL |=> prdata[0] == $past(alarm_msg_sending))
    else $error("sending bit reads wrong");
  a_upper_zero: assert property (@(posedge clk) disable iff (rst)
    $past(setup_ph) && $past(sel) == ds3tx_pkg::SEL_CTRL |-> prdata[7:5] == 3'b000)
    else $error("unused control bits not zero");
  // A fresh trigger edge in mid-message must not rewind the bit or repeat counters
  a_retrig_ign: assert property (@(posedge clk) disable iff (rst)
    alarm_msg_sending && !alarm_slot && wr_en && sel == ds3tx_pkg::SEL_CTRL && wbyte[1]
    && !r_ff.trig |=> alarm_msg_sending
    && ds3tx_feac_ser_i.s_ff.bitcnt == $past(ds3tx_feac_ser_i.s_ff.bitcnt)
    && ds3tx_feac_ser_i.s_ff.repcnt == $past(ds3tx_feac_ser_i.s_ff.repcnt))
    else $error("restart while sending");
  // The slot after the leading zero carries the code's least significant bit
  a_code_lsb: assert property (@(posedge clk) disable iff (rst)
    alarm_msg_sending && alarm_slot && ds3tx_feac_ser_i.s_ff.bitcnt == 4'h1
    |=> alarm_msg_bit == r_ff.code[0])
    else $error("code word not sent LSB first");

  c_msg_done: cover property (@(posedge clk) disable iff (rst) done_req);
  c_irq_up: cover property (@(posedge clk) disable iff (rst) $rose(irq));
  c_fbit_err: cover property (@(posedge clk) disable iff (rst)
    tx_bit_valid && tx_fbit_slot && framing_bit_xor_pattern != 28'h0000000);
  c_retrig: cover property (@(posedge clk) disable iff (rst)
    alarm_msg_sending && wr_en && sel == ds3tx_pkg::SEL_CTRL && wbyte[1] && !r_ff.trig);
endmodule // ds3tx_top

// ==== testbench/ds3tx_far_end.sv ====
module ds3tx_far_end (
  input wire logic clk,
  input wire logic run,
  input wire logic [3:0] gap,
  input wire logic alarm_msg_bit,
  output logic alarm_slot
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt;
  logic slot_seen;
  logic got[$];
  ////////////////////////////////////////////////////////////////////////////////
  // Slot pulses every gap cycles while a message is expected; a large gap models a slow far end
  always @(posedge clk)
  begin
    if (!run)
    begin
      cnt <= 4'h0;
      alarm_slot <= 1'b0;
      got.delete();
    end
    else
    begin
      cnt <= (cnt == gap - 4'h1) ? 4'h0 : cnt + 4'h1;
      alarm_slot <= (cnt == gap - 4'h1);
    end
    // The bit of a slot is registered at that slot's edge, so it is taken one edge later
    slot_seen <= alarm_slot;
    if (slot_seen && run)
      got.push_back(alarm_msg_bit);
  end
endmodule // ds3tx_far_end

// ==== testbench/test_ds3_tx_fbit_inject_feac_ctrl.sv ====
`include "ds3tx_map.svh"
module test_ds3_tx_fbit_inject_feac_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, cbit_mode, run;
  logic tx_bit_in, tx_bit_valid, tx_fbit_slot, tx_mframe_start, tx_bit_out, tx_bit_valid_out;
  logic alarm_slot, alarm_msg_bit;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb, gap;
  int n_errors = 0;
  int n_checks = 0;
  ////////////////////////////////////////////////////////////////////////////////
  ds3tx_top ds3tx_top_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cbit_parity_mode(cbit_mode),
    .tx_bit_in(tx_bit_in), .tx_bit_valid(tx_bit_valid), .tx_fbit_slot(tx_fbit_slot),
    .tx_mframe_start(tx_mframe_start), .tx_bit_out(tx_bit_out),
    .tx_bit_valid_out(tx_bit_valid_out), .alarm_slot(alarm_slot),
    .alarm_msg_bit(alarm_msg_bit), .irq(irq));
  ds3tx_far_end ds3tx_far_end_i (.clk(clk), .run(run), .gap(gap),
    .alarm_msg_bit(alarm_msg_bit), .alarm_slot(alarm_slot));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until pready is seen high at a rising edge; one idle cycle between transfers
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
    output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, idx, d, rd, err);
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, idx, 8'h00, rd, err);
    chk(rd, exp);
  endtask
  // Let the access edge land before looking at the level output
  task automatic irq_chk(input logic e);
    #1;
    chk({31'h0, irq}, {31'h0, e});
  endtask
  function automatic logic msg_bit(input logic [5:0] c, input int j);
    return (j >= 1 && j <= 6) ? c[j - 1] : (j >= 8);
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    logic [31:0] rd;
    logic err;
    rchk(`DS3TX_IDX_MASK_MID, 32'h0);
    rchk(`DS3TX_IDX_MASK_LOW, 32'h0);
    rchk(`DS3TX_IDX_CTRL, 32'h0);
    rchk(`DS3TX_IDX_CODE, 32'h7e);
    rchk(`DS3TX_IDX_IRQ_STS, 32'h0);
    rchk(`DS3TX_IDX_IRQ_MSK, 32'h0);
    apb(1'b0, 8'h00, 8'h00, rd, err);
    chk({rd[30:0], err}, 32'h1);
    // A write with its byte strobe off must leave the register alone
    pstrb <= 4'he;
    wr(`DS3TX_IDX_MASK_MID, 8'hff);
    pstrb <= 4'hf;
    rchk(`DS3TX_IDX_MASK_MID, 32'h0);
    wr(`DS3TX_IDX_CTRL, 8'he9);
    rchk(`DS3TX_IDX_CTRL, 32'h0);
    $display("Reset test done");
  endtask
  task automatic test_fbit();
    logic [27:0] pat;
    logic e;
    int i;
    // Bit 0 set so the first F-bit of each M-frame is inverted
    pat = 28'h000a53d;
    e = 1'b0;
    wr(`DS3TX_IDX_MASK_MID, 8'ha5);
    wr(`DS3TX_IDX_MASK_LOW, 8'h3d);
    rchk(`DS3TX_IDX_MASK_LOW, 32'h3d);
    // Two whole M-frames, F-bits interleaved with data bits, checked one cycle later
    for (int k = 0; k < 113; k++)
    begin
      @(posedge clk);
      i = (k % 56) / 2;
      tx_bit_valid <= (k < 112);
      tx_fbit_slot <= !k[0];
      tx_mframe_start <= (k % 56 == 0) && (k < 112);
      tx_bit_in <= k[1];
      #1;
      if (k > 0)
        chk({30'h0, tx_bit_valid_out, tx_bit_out}, {30'h0, 1'b1, e});
      e = k[1] ^ (!k[0] & pat[i]);
    end
    wr(`DS3TX_IDX_MASK_MID, 8'h00);
    wr(`DS3TX_IDX_MASK_LOW, 8'h00);
    $display("F-bit test done");
  endtask
  task automatic test_refuse();
    wr(`DS3TX_IDX_CTRL, 8'h00);
    wr(`DS3TX_IDX_CTRL, 8'h02);
    rchk(`DS3TX_IDX_CTRL, 32'h02);
    cbit_mode <= 1'b0;
    wr(`DS3TX_IDX_CTRL, 8'h04);
    wr(`DS3TX_IDX_CTRL, 8'h06);
    rchk(`DS3TX_IDX_CTRL, 32'h06);
    cbit_mode <= 1'b1;
    wr(`DS3TX_IDX_CTRL, 8'h06);
    rchk(`DS3TX_IDX_CTRL, 32'h06);
    $display("Refusal test done");
  endtask
  // Host clears then sets the trigger, and retriggers once in mid-message
  task automatic send(input logic [5:0] code, input logic [7:0] ctl, input logic [3:0] g);
    int n;
    wr(`DS3TX_IDX_CODE, {1'b0, code, 1'b0});
    rchk(`DS3TX_IDX_CODE, {25'h0, code, 1'b0});
    wr(`DS3TX_IDX_CTRL, ctl & 8'hfd);
    wr(`DS3TX_IDX_CTRL, ctl);
    gap <= g;
    run <= 1'b1;
    rchk(`DS3TX_IDX_CTRL, {24'h0, ctl | 8'h01});
    wr(`DS3TX_IDX_CTRL, ctl & 8'hfd);
    wr(`DS3TX_IDX_CTRL, ctl);
    for (n = 0; n < 3000 && ds3tx_far_end_i.got.size() < 160; n++)
      @(posedge clk);
    for (n = 0; n < 160; n++)
      chk({31'h0, ds3tx_far_end_i.got[n]}, {31'h0, msg_bit(code, n % 16)});
    rchk(`DS3TX_IDX_CTRL, {24'h0, ctl | {4'h0, ctl[4], 3'h0}});
    run <= 1'b0;
  endtask
  task automatic test_alarm();
    wr(`DS3TX_IDX_IRQ_MSK, 8'h01);
    send(6'h2b, 8'h16, 4'h2);
    irq_chk(1'b1);
    rchk(`DS3TX_IDX_IRQ_STS, 32'h1);
    rchk(`DS3TX_IDX_CTRL, 32'h16);
    wr(`DS3TX_IDX_IRQ_MSK, 8'h00);
    irq_chk(1'b0);
    wr(`DS3TX_IDX_IRQ_MSK, 8'h01);
    irq_chk(1'b1);
    wr(`DS3TX_IDX_IRQ_STS, 8'h01);
    irq_chk(1'b0);
    rchk(`DS3TX_IDX_IRQ_STS, 32'h0);
    send(6'h14, 8'h06, 4'h5);
    irq_chk(1'b0);
    rchk(`DS3TX_IDX_IRQ_STS, 32'h0);
    $display("Alarm message test done");
  endtask
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite, run, tx_bit_in, tx_bit_valid, tx_fbit_slot, tx_mframe_start} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    gap = 4'h2;
    cbit_mode = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_fbit();
    test_refuse();
    test_alarm();
    test_done();
  end
  // Watchdog, well beyond the roughly 1400 cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    test_done();
  end
endmodule // test_ds3_tx_fbit_inject_feac_ctrl
